// [jtg_chan_model.sv]
// Behavioural timer channels that source underflow pulses
`timescale 1ns/1ps
module jtg_chan_model (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic fire_in,
  input wire logic slow_in,
  input wire logic [20:0] sel_in,
  input wire logic [3:0] clk_line_in,
  output jtg_pkg::jtg_uf_s uf_out
);
  logic pend_r;
  logic [20:0] sel_r;
  // A slow channel underflows only on its next clock bus tick
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      pend_r <= 1'b0;
      sel_r <= '0;
      uf_out <= '0;
    end
    else
    begin
      uf_out <= '0;
      if (fire_in)
      begin
        pend_r <= 1'b1;
        sel_r <= sel_in;
      end
      else if (pend_r && (!slow_in || clk_line_in[0]))
      begin
        pend_r <= 1'b0;
        uf_out <= sel_r;
      end
    end
  end
endmodule : jtg_chan_model

// [jtg_consts.svh]
// Register map, field positions and reset values of the junction timer group
`ifndef JTG_CONSTS_SVH
`define JTG_CONSTS_SVH
// Register indices, byte address = 4 * index
`define JTG_IDX_ROUTE 24'h800201
`define JTG_IDX_DIV_A 24'h800202
`define JTG_IDX_DIV_B 24'h800203
`define JTG_IDX_DIV_C 24'h800204
`define JTG_IDX_OUT_ROUTE 24'h800205
`define JTG_ADDR_W 26
`define JTG_RESET_BYTE 8'h00
// Field positions, bit 7 of the byte is doc bit D8 ... bit 0 is D15
`define JTG_F_IN3_HI 7
`define JTG_F_IN3_LO 6
`define JTG_F_IN2_HI 5
`define JTG_F_IN2_LO 4
`define JTG_F_IN1 3
`define JTG_F_IN0 2
`define JTG_F_CK2 0
`define JTG_F_OUT3_HI 7
`define JTG_F_OUT3_LO 6
`define JTG_F_OUT2 4
`define JTG_F_OUT1 2
`define JTG_F_OUT0 0
`define JTG_ROUTE_MASK 8'hfd
`define JTG_OUT_ROUTE_MASK 8'hd5
`define JTG_RESP_OKAY 2'h0
`define JTG_RESP_SLVERR 2'h2
`endif

// [jtg_divider.sv]
// One reloadable 8-bit prescaler of the junction timer group
`timescale 1ns/1ps
module jtg_divider #(
  parameter int WIDTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic half_tick_in,
  input wire logic [WIDTH-1:0] divide_in,
  output logic pulse_out
);
  logic [WIDTH-1:0] count_r;

  initial
  begin
    if (WIDTH < 1) $error("jtg_divider: WIDTH must be positive");
  end

  // ----------------------------------------------------------------
  // Down counter, reloads from the divide value only at underflow
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      count_r <= '0;
    else if (clk_en_in && half_tick_in)
    begin
      if (count_r == '0)
        count_r <= divide_in; // R3 R19
      else
        count_r <= count_r - 1'b1; // R1
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      pulse_out <= 1'b0;
    else if (clk_en_in)
      pulse_out <= half_tick_in && (count_r == '0); // R19
  end
endmodule : jtg_divider

// [jtg_pkg.sv]
// Types shared by the junction timer group files
package jtg_pkg;
  typedef struct packed {
    logic [10:0] top_uf;
    logic [9:0] tio_uf;
  } jtg_uf_s;
  typedef struct packed {
    logic [3:0] clk_line;
    logic [3:0] in_event;
    logic [3:0] out_event;
  } jtg_bus_s;
endpackage : jtg_pkg

// [jtg_router.sv]
// Prescalers and clock / event bus routing of the junction timer group
//
// How it works
// R1 - Three 8-bit down-count prescalers run at half the peripheral clock.
// R2 - Divide registers reset to zero; prescalers count right after reset.
// R3 - A new divide value is taken only at the next underflow.
// R4 - Divide registers accept every value from 0 to 255.
// R5 - Counting needs no enable; it starts when reset is released.
// R6 - Clock lines 0,1 carry prescalers 0,1; line 3 carries ext clock a.
// R7 - Clock line 2 carries prescaler 2, or ext clock d when bit set.
// R8 - Four input event lines offer enable or capture strobes to channels.
// R9 - In-line 3: 0X ext event d, 10 out-line 2, 11 io timer 7.
// R10 - In-line 2: 00 ext event a; 01 and 1X leave it idle.
// R11 - In-line 1 carries io timer 6 underflow when its bit is 1.
// R12 - In-line 0 carries io timer 5 underflow when its bit is 1.
// R13 - Four output event lines are fed from chosen timer underflows.
// R14 - Out-lines feed flip-flops; 3 converter, 0 and 1 DMA, 2 in-line 3.
// R15 - Channels pulse their event line on each counter underflow.
// R16 - Measure timers produce no event bus signal.
// R17 - Io timers 5 and 6 also feed the input event selectors.
// R18 - Out-line 3: 00 out 8, 01 io 3, 10 io 4, 11 io 8; others 0/1.
// R19 - Value N divides by N+1 with a one-cycle pulse per underflow.
// R20 - Unassigned route bit reads zero and ignores writes.
`timescale 1ns/1ps
`include "jtg_consts.svh"
module jtg_router #(
  parameter int DIV_W = 8
) (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  // AXI4-Lite slave
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Processed external inputs, already on this clock
  input wire logic ext_clock_in_a_in,
  input wire logic ext_clock_in_d_in,
  input wire logic ext_event_in_a_in,
  input wire logic ext_event_in_d_in,
  // Underflow pulses from the timer channels
  input wire jtg_pkg::jtg_uf_s uf_in,
  // Routed buses
  output jtg_pkg::jtg_bus_s bus_out,
  output logic adc0_trigger_out,
  output logic dma_ch1_req_out,
  output logic dma_ch2_req_out
);
  logic half_tick_r;
  logic [DIV_W-1:0] divider_a_r;
  logic [DIV_W-1:0] divider_b_r;
  logic [DIV_W-1:0] divider_c_r;
  logic [7:0] clock_event_route_reg_r;
  logic [7:0] out_event_route_reg_r;
  logic [2:0] div_pulse;
  logic [3:0] out_event_nxt;
  logic [3:0] in_event_nxt;
  logic [3:0] clk_line_nxt;
  logic [1:0] out_event_line3_source;
  logic [1:0] in_event_line3_source;
  logic [1:0] in_event_line2_source;
  logic aw_held_r;
  logic w_held_r;
  logic [31:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [`JTG_ADDR_W-1:0] wr_idx;
  logic [`JTG_ADDR_W-1:0] rd_idx;
  logic wr_fire;
  logic [7:0] rd_byte;
  logic rd_hit;

  initial
  begin
    if (DIV_W != 8) $error("jtg_router: registers are 8 bits wide");
  end

  // ----------------------------------------------------------------
  // Half-rate tick and prescalers
  // ----------------------------------------------------------------
  // Free-running: counting starts with no enable once reset lifts
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      half_tick_r <= 1'b0;
    else if (clk_en_in)
      half_tick_r <= ~half_tick_r; // R1 R5
  end

  jtg_divider #(.WIDTH(DIV_W)) u_div_a (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .half_tick_in(half_tick_r),
    .divide_in(divider_a_r),
    .pulse_out(div_pulse[0])
  );

  jtg_divider #(.WIDTH(DIV_W)) u_div_b (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .half_tick_in(half_tick_r),
    .divide_in(divider_b_r),
    .pulse_out(div_pulse[1])
  );

  jtg_divider #(.WIDTH(DIV_W)) u_div_c (
    .ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in),
    .clk_en_in(clk_en_in),
    .half_tick_in(half_tick_r),
    .divide_in(divider_c_r),
    .pulse_out(div_pulse[2])
  );

  // ----------------------------------------------------------------
  // Bus routing
  // ----------------------------------------------------------------
  assign out_event_line3_source =
    out_event_route_reg_r[`JTG_F_OUT3_HI:`JTG_F_OUT3_LO];
  assign in_event_line3_source =
    clock_event_route_reg_r[`JTG_F_IN3_HI:`JTG_F_IN3_LO];
  assign in_event_line2_source =
    clock_event_route_reg_r[`JTG_F_IN2_HI:`JTG_F_IN2_LO];

  // Measure timers have no inputs here at all
  always_comb
  begin
    unique case (out_event_line3_source) // R13 R18
      2'h0: out_event_nxt[3] = uf_in.top_uf[8];
      2'h1: out_event_nxt[3] = uf_in.tio_uf[3];
      2'h2: out_event_nxt[3] = uf_in.tio_uf[4];
      2'h3: out_event_nxt[3] = uf_in.tio_uf[8];
    endcase
    out_event_nxt[2] = out_event_route_reg_r[`JTG_F_OUT2] ?
      uf_in.tio_uf[2] : uf_in.top_uf[9]; // R18
    out_event_nxt[1] = out_event_route_reg_r[`JTG_F_OUT1] ?
      uf_in.tio_uf[1] : uf_in.top_uf[7]; // R18
    out_event_nxt[0] = out_event_route_reg_r[`JTG_F_OUT0] ?
      uf_in.tio_uf[0] : uf_in.top_uf[6]; // R18
  end

  always_comb
  begin
    unique case (in_event_line3_source) // R9
      2'h0: in_event_nxt[3] = ext_event_in_d_in;
      2'h1: in_event_nxt[3] = ext_event_in_d_in;
      2'h2: in_event_nxt[3] = out_event_nxt[2]; // R14
      2'h3: in_event_nxt[3] = uf_in.tio_uf[7];
    endcase
    in_event_nxt[2] = (in_event_line2_source == 2'h0) &&
      ext_event_in_a_in; // R10
    in_event_nxt[1] = clock_event_route_reg_r[`JTG_F_IN1] &&
      uf_in.tio_uf[6]; // R11 R17
    in_event_nxt[0] = clock_event_route_reg_r[`JTG_F_IN0] &&
      uf_in.tio_uf[5]; // R12 R17
    clk_line_nxt[3] = ext_clock_in_a_in; // R6
    clk_line_nxt[2] = clock_event_route_reg_r[`JTG_F_CK2] ?
      ext_clock_in_d_in : div_pulse[2]; // R7
    clk_line_nxt[1] = div_pulse[1]; // R6
    clk_line_nxt[0] = div_pulse[0]; // R6
  end

  // Buses leave from flip-flops: one cycle after the source pulse
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      bus_out <= '0;
    else if (clk_en_in)
    begin
      bus_out.clk_line <= clk_line_nxt;
      bus_out.in_event <= in_event_nxt; // R8
      bus_out.out_event <= out_event_nxt; // R13
    end
  end

  assign adc0_trigger_out = bus_out.out_event[3]; // R14
  assign dma_ch1_req_out = bus_out.out_event[0]; // R14
  assign dma_ch2_req_out = bus_out.out_event[1]; // R14

  // ----------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready = !w_held_r && !s_axi_bvalid;
  assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_idx = awaddr_r[`JTG_ADDR_W+1:2];

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      aw_held_r <= 1'b0;
      w_held_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
    end
    else if (clk_en_in)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end
      else if (wr_fire)
        aw_held_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end
      else if (wr_fire)
        w_held_r <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `JTG_RESP_OKAY;
    end
    else if (clk_en_in)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (wr_idx == `JTG_IDX_ROUTE ||
          wr_idx == `JTG_IDX_DIV_A || wr_idx == `JTG_IDX_DIV_B ||
          wr_idx == `JTG_IDX_DIV_C || wr_idx == `JTG_IDX_OUT_ROUTE) ?
          `JTG_RESP_OKAY : `JTG_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Registers take the low byte lane only
  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      clock_event_route_reg_r <= `JTG_RESET_BYTE; // R2
      out_event_route_reg_r <= `JTG_RESET_BYTE;
      divider_a_r <= `JTG_RESET_BYTE; // R2
      divider_b_r <= `JTG_RESET_BYTE;
      divider_c_r <= `JTG_RESET_BYTE;
    end
    else if (clk_en_in && wr_fire && wstrb_r[0])
    begin
      unique case (wr_idx)
        `JTG_IDX_ROUTE:
          clock_event_route_reg_r <= wdata_r[7:0] & `JTG_ROUTE_MASK; // R20
        `JTG_IDX_OUT_ROUTE:
          out_event_route_reg_r <= wdata_r[7:0] & `JTG_OUT_ROUTE_MASK;
        `JTG_IDX_DIV_A: divider_a_r <= wdata_r[7:0]; // R4
        `JTG_IDX_DIV_B: divider_b_r <= wdata_r[7:0]; // R4
        `JTG_IDX_DIV_C: divider_c_r <= wdata_r[7:0]; // R4
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------
  assign rd_idx = s_axi_araddr[`JTG_ADDR_W+1:2];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb
  begin
    rd_hit = 1'b1;
    unique case (rd_idx)
      `JTG_IDX_ROUTE: rd_byte = clock_event_route_reg_r;
      `JTG_IDX_OUT_ROUTE: rd_byte = out_event_route_reg_r;
      `JTG_IDX_DIV_A: rd_byte = divider_a_r;
      `JTG_IDX_DIV_B: rd_byte = divider_b_r;
      `JTG_IDX_DIV_C: rd_byte = divider_c_r;
      default:
      begin
        rd_byte = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `JTG_RESP_OKAY;
    end
    else if (clk_en_in)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_hit ? `JTG_RESP_OKAY : `JTG_RESP_SLVERR;
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule : jtg_router

// [jtg_router_props.sv]
// Port checker for the junction timer group router
`timescale 1ns/1ps
module jtg_router_props (
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic clk_en_in,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic ext_clock_in_a_in,
  input wire jtg_pkg::jtg_bus_s bus_out,
  input wire logic adc0_trigger_out,
  input wire logic dma_ch1_req_out,
  input wire logic dma_ch2_req_out
);
  default clocking dc @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  // ----
  // Handshake and routing checks
  // ----
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("bresp dropped");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("rdata dropped");
  read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid) else $error("read answer late");
  // Address and data are held one cycle before the write fires, so the answer comes two cycles later
  write_answer_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  busy_block_a: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while busy");
  upper_zero_a: assert property (s_axi_rvalid |->
    s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
  clk3_follow_a: assert property (clk_en_in |=>
    bus_out.clk_line[3] == $past(ext_clock_in_a_in))
    else $error("clock line 3 wrong");
  side_mirror_a: assert property ({adc0_trigger_out, dma_ch2_req_out,
    dma_ch1_req_out} == {bus_out.out_event[3], bus_out.out_event[1:0]})
    else $error("side outputs wrong");
  clk1_pulse_a: assert property (bus_out.clk_line[1] |=>
    !bus_out.clk_line[1]) else $error("clock pulse too long");
  write_c: cover property (s_axi_bvalid && s_axi_bready);
  read_c: cover property (s_axi_rvalid && s_axi_rready);
  clk_c: cover property (bus_out.clk_line[2]);
  evt_c: cover property (bus_out.in_event[3] && bus_out.out_event[2]);
endmodule : jtg_router_props
bind jtg_router jtg_router_props jtg_router_props_inst (.*);

// [jtg_router_tb_top.sv]
// Self-checking bench for the junction timer group router
`timescale 1ns/1ps
`include "jtg_consts.svh"
`define CHK(w, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) \
    begin \
      bad_count++; \
      $display("unexpected %s: expected %h seen %h", w, e, g); \
    end \
  end
module jtg_router_tb_top;
  logic ref_clk_in, rst_n_in, clk_en_in, fire, slow;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic ext_clock_in_a_in, ext_clock_in_d_in;
  logic ext_event_in_a_in, ext_event_in_d_in;
  logic adc0_trigger_out, dma_ch1_req_out, dma_ch2_req_out;
  logic [20:0] sel;
  jtg_pkg::jtg_uf_s uf_in;
  jtg_pkg::jtg_bus_s bus_out;
  int bad_count, samples_checked, cyc, c0;
  localparam logic [1:0] ERR = `JTG_RESP_SLVERR;
  localparam logic [51:0] ROWS [14] = '{
    {8'h00, 8'h00, 21'h0, 5'h0a, 10'h240},
    {8'h10, 8'h00, 21'h0, 5'h02, 10'h000},
    {8'h20, 8'h00, 21'h0, 5'h02, 10'h000},
    {8'h40, 8'h00, 21'h0, 5'h04, 10'h080},
    {8'h80, 8'h00, 21'h080000, 5'h00, 10'h084},
    {8'hc0, 8'h00, 21'h80, 5'h00, 10'h080},
    {8'h0c, 8'h00, 21'h60, 5'h01, 10'h030},
    {8'h00, 8'h00, 21'h60, 5'h00, 10'h000},
    {8'h00, 8'h00, 21'h0f0000, 5'h00, 10'h00f},
    {8'h00, 8'h55, 21'h00000f, 5'h00, 10'h00f},
    {8'h00, 8'h80, 21'h10, 5'h00, 10'h008},
    {8'h00, 8'hc0, 21'h100, 5'h00, 10'h008},
    {8'h00, 8'h55, 21'h0f0000, 5'h00, 10'h000},
    {8'h01, 8'h00, 21'h0, 5'h10, 10'h100}};
  jtg_router jtg_router_inst (.*);
  jtg_chan_model jtg_chan_model_inst (.ref_clk_in(ref_clk_in),
    .rst_n_in(rst_n_in), .fire_in(fire), .slow_in(slow), .sel_in(sel),
    .clk_line_in(bus_out.clk_line), .uf_out(uf_in));
  initial
  begin
    ref_clk_in = 1'b0;
    forever #50 ref_clk_in = ~ref_clk_in;
  end
  always @(posedge ref_clk_in) cyc <= cyc + 1;
  task automatic wr(input logic [23:0] i, input logic [7:0] d,
    input logic [1:0] e = 2'h0);
    logic a, w, ta, tw;
    a = 1'b0;
    w = 1'b0;
    @(posedge ref_clk_in);
    s_axi_awaddr <= {6'h0, i, 2'b00};
    s_axi_wdata <= {24'h0, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
    while (!(a && w))
    begin
      @(negedge ref_clk_in);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      @(posedge ref_clk_in);
      if (ta)
      begin
        s_axi_awvalid <= 1'b0;
        a = 1'b1;
      end
      if (tw)
      begin
        s_axi_wvalid <= 1'b0;
        w = 1'b1;
      end
    end
    do @(negedge ref_clk_in); while (s_axi_bvalid !== 1'b1);
    `CHK("bresp", e, s_axi_bresp)
    @(posedge ref_clk_in);
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [23:0] i, input logic [7:0] d,
    input logic [1:0] e = 2'h0);
    logic t;
    t = 1'b0;
    @(posedge ref_clk_in);
    s_axi_araddr <= {6'h0, i, 2'b00};
    {s_axi_arvalid, s_axi_rready} <= 2'h3;
    while (!t)
    begin
      @(negedge ref_clk_in);
      t = s_axi_arready;
      @(posedge ref_clk_in);
    end
    s_axi_arvalid <= 1'b0;
    do @(negedge ref_clk_in); while (s_axi_rvalid !== 1'b1);
    `CHK("rdata", {24'h0, d}, s_axi_rdata)
    `CHK("rresp", e, s_axi_rresp)
    @(posedge ref_clk_in);
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic pw(input int n);
    do @(negedge ref_clk_in); while (bus_out.clk_line[n] !== 1'b1);
  endtask : pw
  task automatic per(input int n, input int e);
    pw(n);
    c0 = cyc;
    pw(n);
    `CHK("period", e, cyc - c0)
  endtask : per
  task automatic row(input logic [51:0] r);
    logic [9:0] acc;
    acc = '0;
    wr(`JTG_IDX_ROUTE, r[51:44]);
    wr(`JTG_IDX_OUT_ROUTE, r[43:36]);
    @(posedge ref_clk_in);
    {ext_clock_in_d_in, ext_clock_in_a_in} <= r[14:13];
    {ext_event_in_d_in, ext_event_in_a_in} <= r[12:11];
    {fire, sel, slow} <= {1'b1, r[35:15], r[10]};
    @(posedge ref_clk_in);
    {ext_clock_in_d_in, ext_clock_in_a_in, fire} <= 3'h0;
    {ext_event_in_d_in, ext_event_in_a_in} <= 2'h0;
    repeat (6)
    begin
      @(negedge ref_clk_in);
      acc |= {bus_out.clk_line[3], bus_out.clk_line[2] & r[44],
        bus_out.in_event, bus_out.out_event};
    end
    `CHK("routes", r[9:0], acc)
  endtask : row
  task automatic finish_test;
    $display("compared %0d mismatched %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : finish_test
  initial
  begin
    {rst_n_in, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, fire, slow, sel, cyc} = '0;
    {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {ext_clock_in_a_in, ext_clock_in_d_in} = '0;
    {ext_event_in_a_in, ext_event_in_d_in} = '0;
    clk_en_in = 1'b1;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    for (logic [23:0] a = `JTG_IDX_ROUTE; a < 24'h800206; a++)
      rd(a, 8'h00);
    rd(24'h800206, 8'h00, ERR);
    wr(24'h800206, 8'h5a, ERR);
    per(0, 2);
    per(1, 2);
    wr(`JTG_IDX_DIV_A, 8'hff);
    rd(`JTG_IDX_DIV_A, 8'hff);
    wr(`JTG_IDX_DIV_A, 8'h00);
    wr(`JTG_IDX_ROUTE, 8'hff);
    rd(`JTG_IDX_ROUTE, 8'hfd);
    wr(`JTG_IDX_OUT_ROUTE, 8'hff);
    rd(`JTG_IDX_OUT_ROUTE, 8'hd5);
    $display("registers done");
    wr(`JTG_IDX_DIV_B, 8'h09);
    pw(1);
    pw(1);
    c0 = cyc;
    wr(`JTG_IDX_DIV_B, 8'h01);
    pw(1);
    `CHK("old period", 20, cyc - c0)
    per(1, 4);
    pw(1);
    @(posedge ref_clk_in);
    clk_en_in <= 1'b0;
    c0 = 0;
    repeat (8)
    begin
      @(negedge ref_clk_in);
      c0 += bus_out.clk_line[1];
    end
    `CHK("frozen", 0, c0)
    @(posedge ref_clk_in);
    clk_en_in <= 1'b1;
    per(1, 4);
    wr(`JTG_IDX_ROUTE, 8'h00);
    wr(`JTG_IDX_DIV_C, 8'hff);
    pw(2);
    per(2, 512);
    $display("prescalers done");
    foreach (ROWS[k]) row(ROWS[k]);
    c0 = 0;
    repeat (520)
    begin
      @(negedge ref_clk_in);
      c0 += bus_out.clk_line[2];
    end
    `CHK("line 2 quiet", 0, c0)
    $display("routing done");
    finish_test;
  end
  initial
  begin
    #3000000;
    bad_count++;
    finish_test;
  end
endmodule : jtg_router_tb_top
